// ### isr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module isr_host_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_slow,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic [7:0] got[$];
  logic [1:0] phase_r;
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      phase_r <= 2'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (i_tx_valid && o_tx_ready) begin
        got.push_back(i_tx_data);
      end
    end
  end
  // slow host takes one cycle in four so chars must be held
  assign o_tx_ready = !i_slow || (phase_r == 2'h3);
endmodule
`default_nettype wire

// ### isr_pkg.sv
package isr_pkg;

  // query kinds as decoded by the command parser upstream
  typedef enum logic [1:0] {
    ISR_Q_ANALOG  = 2'h0,
    ISR_Q_CURRENT = 2'h1,
    ISR_Q_DIST    = 2'h2,
    ISR_Q_ENC     = 2'h3
  } isr_query_kind_type;

  typedef struct packed {
    isr_query_kind_type kind;
    logic has_param;
    logic [3:0] param;
  } isr_query_type;

  typedef struct packed {
    logic [15:0] analog_cmd;
    logic [15:0] analog_in1;
    logic [15:0] analog_in2;
    logic [15:0] analog_exp;
  } isr_analog_type;

  typedef struct packed {
    logic [15:0] run_current;
    logic [15:0] accel_current;
    logic [15:0] idle_current;
  } isr_step_current_type;

  // analog query selectors
  localparam logic [3:0] ISR_AQ_CMD = 4'h0;
  localparam logic [3:0] ISR_AQ_IN1 = 4'h1;
  localparam logic [3:0] ISR_AQ_IN2 = 4'h2;
  localparam logic [3:0] ISR_AQ_EXP = 4'h3;

  // internal data register access codes (decimal codes held in binary)
  localparam logic [7:0] ISR_RC_ANALOG_CMD = 8'h31;
  localparam logic [7:0] ISR_RC_CURRENT = 8'h33;
  localparam logic [7:0] ISR_RC_DIST = 8'h34;
  localparam logic [7:0] ISR_RC_ENC = 8'h35;
  localparam logic [7:0] ISR_RC_ANALOG_IN1 = 8'h3a;
  localparam logic [7:0] ISR_RC_ANALOG_IN2 = 8'h3b;

  // reply characters
  localparam logic [7:0] ISR_CH_LEAD = 8'h49;
  localparam logic [7:0] ISR_CH_ANALOG = 8'h41;
  localparam logic [7:0] ISR_CH_CURRENT = 8'h43;
  localparam logic [7:0] ISR_CH_DIST = 8'h44;
  localparam logic [7:0] ISR_CH_ENC = 8'h45;
  localparam logic [7:0] ISR_CH_EQUALS = 8'h3d;
  localparam logic [7:0] ISR_CH_MINUS = 8'h2d;
  localparam logic [7:0] ISR_CH_CR = 8'h0d;
  localparam logic [7:0] ISR_CH_ZERO = 8'h30;
  localparam logic [7:0] ISR_CH_ALPHA = 8'h37;

  // hex field widths in nibbles; short shift in bits, top decimal power, last name char index
  localparam logic [3:0] ISR_NIB_SHORT = 4'h4;
  localparam logic [3:0] ISR_NIB_LONG = 4'h8;
  localparam int ISR_SHORT_SHIFT = 16;
  localparam logic [3:0] ISR_DEC_TOP = 4'h9;
  localparam logic [1:0] ISR_NAME_LAST = 2'h2;

endpackage

// ### isr_readback_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none
module isr_readback_chk
  import isr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_query_valid,
  input wire isr_query_type i_query,
  input wire logic o_query_ready,
  input wire logic o_query_reject,
  input wire logic i_format_valid,
  input wire logic i_format_decimal,
  input wire logic o_format_decimal,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire isr_analog_type i_analog,
  input wire logic [31:0] i_encoder_pos,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_code,
  input wire logic [31:0] o_reg_data,
  input wire logic o_reg_hit
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  wire logic query_take = i_query_valid && o_query_ready;
  chk_take_lead: assert property (query_take |=>
    o_query_reject ^ (o_tx_valid && o_tx_data == ISR_CH_LEAD)) else $error("no lead char");
  chk_busy_ready: assert property (o_tx_valid |-> !o_query_ready)
    else $error("ready during reply");
  chk_char_hold: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("char dropped");
  chk_reject_why: assert property (o_query_reject |-> $past(query_take &&
    i_query.kind == ISR_Q_ANALOG && i_query.has_param && i_query.param > ISR_AQ_EXP))
    else $error("reject without cause");
  chk_fmt_store: assert property (i_format_valid |=>
    o_format_decimal == $past(i_format_decimal)) else $error("format not stored");
  chk_reset_hex: assert property ($fell(i_reset) |-> !o_format_decimal)
    else $error("format not hex after reset");
  chk_enc_read: assert property (i_reg_read && i_reg_code == ISR_RC_ENC |=>
    o_reg_hit && o_reg_data == $past(i_encoder_pos)) else $error("encoder reg wrong");
  chk_in2_read: assert property (i_reg_read && i_reg_code == ISR_RC_ANALOG_IN2 |=>
    o_reg_hit && o_reg_data == {16'h0000, $past(i_analog.analog_in2)})
    else $error("analog reg wrong");
endmodule
bind isr_status_readback isr_readback_chk isr_readback_chk_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_query_valid(i_query_valid),
  .i_query(i_query), .o_query_ready(o_query_ready), .o_query_reject(o_query_reject),
  .i_format_valid(i_format_valid), .i_format_decimal(i_format_decimal),
  .o_format_decimal(o_format_decimal), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
  .i_tx_ready(i_tx_ready), .i_analog(i_analog), .i_encoder_pos(i_encoder_pos),
  .i_reg_read(i_reg_read), .i_reg_code(i_reg_code), .o_reg_data(o_reg_data),
  .o_reg_hit(o_reg_hit)
);
`default_nettype wire

// ### isr_status_readback.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// - param none or 0 returns scaled analog command
// - params 1,2,3 return raw analog inputs
// - analog reply follows hex or decimal format
// - hex analog reply is exactly four digits
// - decimal reply drops leading zeros, variable length
// - servo current is signed commanded rms current
// - stepper current: run/accel moving, idle stopped
// - first variant: distance of last completed move
// - other variants: track, hold, clear on start
// - encoder query returns signed encoder position
// - analog values readable at codes 049,058,059
// - reset selects hexadecimal reply format
// - queries answered at once, not queued
module isr_status_readback #(
  parameter bit SERVO_DRIVE = 1'b1,
  parameter bit LAST_MOVE_ONLY = 1'b0,
  parameter bit HAS_EXPANDED = 1'b1
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_query_valid,
  input wire isr_pkg::isr_query_type i_query,
  output logic o_query_ready,
  output logic o_query_reject,
  input wire logic i_format_valid,
  input wire logic i_format_decimal,
  output logic o_format_decimal,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire isr_pkg::isr_analog_type i_analog,
  input wire logic [15:0] i_servo_current,
  input wire isr_pkg::isr_step_current_type i_step_current,
  input wire logic i_moving,
  input wire logic i_accelerating,
  input wire logic i_move_start,
  input wire logic [31:0] i_move_progress,
  input wire logic [31:0] i_encoder_pos,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_code,
  output logic [31:0] o_reg_data,
  output logic o_reg_hit
);
  import isr_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_NAME = 6'b000010,
    ST_SIGN = 6'b000100,
    ST_HEX = 6'b001000,
    ST_DIV = 6'b010000,
    ST_DIG = 6'b100000
  } isr_state_type;

  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? ISR_CH_ZERO + {4'h0, nib} : ISR_CH_ALPHA + {4'h0, nib};
  endfunction

  function automatic logic [31:0] pow10(input logic [3:0] p);
    case (p)
      4'h0: pow10 = 32'h0000_0001;
      4'h1: pow10 = 32'h0000_000a;
      4'h2: pow10 = 32'h0000_0064;
      4'h3: pow10 = 32'h0000_03e8;
      4'h4: pow10 = 32'h0000_2710;
      4'h5: pow10 = 32'h0001_86a0;
      4'h6: pow10 = 32'h000f_4240;
      4'h7: pow10 = 32'h0098_9680;
      4'h8: pow10 = 32'h05f5_e100;
      default: pow10 = 32'h3b9a_ca00;
    endcase
  endfunction

  isr_state_type state_r;
  logic fmt_dec_r;
  logic [31:0] dist_r;
  logic [31:0] val_r;
  logic [3:0] cnt_r;
  logic [3:0] digit_r;
  logic started_r;
  logic [1:0] name_r;
  logic [7:0] letter_r;
  logic [7:0] chr_r;
  logic reject_r;
  logic [31:0] reg_data_r;
  logic reg_hit_r;

  // reply format: hex after reset, decimal only once selected
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      fmt_dec_r <= 1'b0;
    end else if (i_format_valid) begin
      fmt_dec_r <= i_format_decimal;
    end
  end

  // move distance: first variant latches at end of move only
  logic dist_track_r;
  wire move_end = !i_moving && dist_track_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      dist_r <= 32'h0000_0000;
      dist_track_r <= 1'b0;
    end else begin
      dist_track_r <= i_moving;
      if (LAST_MOVE_ONLY) begin
        if (move_end) begin
          dist_r <= i_move_progress;
        end
      end else if (i_move_start) begin
        dist_r <= 32'h0000_0000;
      end else if (i_moving) begin
        dist_r <= i_move_progress;
      end
    end
  end

  // stepper phase current follows motion state
  wire [15:0] step_cur = !i_moving ? i_step_current.idle_current :
    (i_accelerating ? i_step_current.accel_current : i_step_current.run_current);
  wire [15:0] cur_val = SERVO_DRIVE ? i_servo_current : step_cur;

  wire [3:0] a_sel = i_query.has_param ? i_query.param : ISR_AQ_CMD;
  wire a_ok = (a_sel <= ISR_AQ_IN2) || (a_sel == ISR_AQ_EXP && HAS_EXPANDED);
  wire [15:0] a_val = (a_sel == ISR_AQ_IN1) ? i_analog.analog_in1 :
    (a_sel == ISR_AQ_IN2) ? i_analog.analog_in2 :
    (a_sel == ISR_AQ_EXP) ? i_analog.analog_exp :
    i_analog.analog_cmd;

  wire is_analog = i_query.kind == ISR_Q_ANALOG;
  wire is_short = is_analog || i_query.kind == ISR_Q_CURRENT;
  wire [15:0] short_val = is_analog ? a_val : cur_val;
  wire [31:0] long_val = (i_query.kind == ISR_Q_DIST) ? dist_r : i_encoder_pos;
  // analog values are unsigned; current, distance, encoder are signed
  wire q_neg = is_short ? (!is_analog && short_val[15]) : long_val[31];
  wire [31:0] q_ext = is_short ? {{16{short_val[15] & !is_analog}}, short_val} : long_val;
  wire [31:0] q_mag = q_neg ? (32'h0000_0000 - q_ext) : q_ext;
  wire [31:0] q_hex = is_short ? {short_val, 16'h0000} : long_val;
  wire [7:0] q_letter = is_analog ? ISR_CH_ANALOG :
    (i_query.kind == ISR_Q_CURRENT) ? ISR_CH_CURRENT :
    (i_query.kind == ISR_Q_DIST) ? ISR_CH_DIST : ISR_CH_ENC;

  wire q_take = i_query_valid && state_r == ST_IDLE;
  wire tx_step = o_tx_valid && i_tx_ready;
  wire [31:0] cur_pow = pow10(cnt_r);
  wire div_more = val_r >= cur_pow;
  wire div_emit = digit_r != 4'h0 || started_r || cnt_r == 4'h0;

  // next hex digit of the value field, shared by the name and hex states
  wire [7:0] first_hex = hex_char(val_r[31:28]);

  isr_state_type state_nxt;
  logic [7:0] chr_nxt;
  always_comb begin
    state_nxt = state_r;
    chr_nxt = chr_r;
    case (state_r)
      ST_IDLE: begin
        if (q_take && !(is_analog && !a_ok)) begin
          state_nxt = ST_NAME;
          chr_nxt = ISR_CH_LEAD;
        end
      end
      ST_NAME: begin
        if (tx_step) begin
          if (name_r == 2'h0) begin
            chr_nxt = letter_r;
          end else if (name_r == 2'h1) begin
            chr_nxt = ISR_CH_EQUALS;
          end else if (!fmt_dec_r) begin
            state_nxt = ST_HEX;
            chr_nxt = first_hex;
          end else if (started_r) begin
            state_nxt = ST_SIGN;
            chr_nxt = ISR_CH_MINUS;
          end else begin
            state_nxt = ST_DIV;
          end
        end
      end
      ST_SIGN: begin
        if (tx_step) begin
          state_nxt = ST_DIV;
        end
      end
      ST_HEX: begin
        if (tx_step) begin
          // cnt_r counts digits still to follow; wraps to 4'hf while the terminator shows
          chr_nxt = (cnt_r == 4'h0) ? ISR_CH_CR : first_hex;
          if (cnt_r == 4'hf) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_DIV: begin
        if (!div_more && div_emit) begin
          state_nxt = ST_DIG;
          chr_nxt = ISR_CH_ZERO + {4'h0, digit_r};
        end
      end
      ST_DIG: begin
        if (tx_step) begin
          if (digit_r == 4'hf) begin
            state_nxt = ST_IDLE;
          end else if (cnt_r == 4'h0) begin
            chr_nxt = ISR_CH_CR;
          end else begin
            state_nxt = ST_DIV;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // datapath: started_r doubles as the sign flag until digits start
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      chr_r <= 8'h00;
      val_r <= 32'h0000_0000;
      cnt_r <= 4'h0;
      digit_r <= 4'h0;
      started_r <= 1'b0;
      name_r <= 2'h0;
      letter_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      chr_r <= chr_nxt;
      case (state_r)
        ST_IDLE: begin
          name_r <= 2'h0;
          digit_r <= 4'h0;
          letter_r <= q_letter;
          val_r <= fmt_dec_r ? q_mag : q_hex;
          started_r <= fmt_dec_r && q_neg;
          cnt_r <= fmt_dec_r ? ISR_DEC_TOP : (is_short ? ISR_NIB_SHORT : ISR_NIB_LONG);
        end
        ST_NAME: begin
          if (tx_step) begin
            name_r <= name_r + 2'h1;
            if (name_r == ISR_NAME_LAST && !fmt_dec_r) begin
              val_r <= {val_r[27:0], 4'h0};
              cnt_r <= cnt_r - 4'h1;
            end
            if (name_r == ISR_NAME_LAST && fmt_dec_r) begin
              started_r <= 1'b0;
            end
          end
        end
        ST_SIGN: begin
          // the digit position must survive the sign character
          cnt_r <= cnt_r;
        end
        ST_HEX: begin
          if (tx_step) begin
            val_r <= {val_r[27:0], 4'h0};
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_DIV: begin
          if (div_more) begin
            val_r <= val_r - cur_pow;
            digit_r <= digit_r + 4'h1;
          end else if (div_emit) begin
            started_r <= 1'b1;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ST_DIG: begin
          if (tx_step) begin
            // 4'hf marks the terminator already being shown
            if (cnt_r == 4'h0) begin
              digit_r <= 4'hf;
            end else begin
              digit_r <= 4'h0;
              cnt_r <= cnt_r - 4'h1;
            end
          end
        end
        default: begin
          cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // out-of-range analog selector is refused without a reply
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= q_take && is_analog && !a_ok;
    end
  end

  wire [31:0] reg_sel = (i_reg_code == ISR_RC_ANALOG_CMD) ? {16'h0000, i_analog.analog_cmd} :
    (i_reg_code == ISR_RC_ANALOG_IN1) ? {16'h0000, i_analog.analog_in1} :
    (i_reg_code == ISR_RC_ANALOG_IN2) ? {16'h0000, i_analog.analog_in2} :
    (i_reg_code == ISR_RC_CURRENT) ? {{16{cur_val[15]}}, cur_val} :
    (i_reg_code == ISR_RC_DIST) ? dist_r :
    (i_reg_code == ISR_RC_ENC) ? i_encoder_pos : 32'h0000_0000;
  wire reg_known = i_reg_code == ISR_RC_ANALOG_CMD || i_reg_code == ISR_RC_ANALOG_IN1 ||
    i_reg_code == ISR_RC_ANALOG_IN2 || i_reg_code == ISR_RC_CURRENT ||
    i_reg_code == ISR_RC_DIST || i_reg_code == ISR_RC_ENC;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      reg_data_r <= 32'h0000_0000;
      reg_hit_r <= 1'b0;
    end else begin
      reg_hit_r <= i_reg_read && reg_known;
      if (i_reg_read) begin
        reg_data_r <= reg_sel;
      end
    end
  end

  assign o_query_ready = state_r == ST_IDLE;
  assign o_query_reject = reject_r;
  assign o_format_decimal = fmt_dec_r;
  assign o_tx_valid = state_r == ST_NAME || state_r == ST_SIGN || state_r == ST_HEX ||
    state_r == ST_DIG;
  assign o_tx_data = chr_r;
  assign o_reg_data = reg_data_r;
  assign o_reg_hit = reg_hit_r;

endmodule

`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import isr_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_query_valid = 1'b0, i_format_valid = 1'b0, i_format_decimal = 1'b0;
  logic i_moving = 1'b0, i_accelerating = 1'b0, i_move_start = 1'b0, i_reg_read = 1'b0;
  logic host_slow = 1'b0;
  isr_query_type i_query = '0;
  isr_analog_type i_analog = {16'h1fee, 16'h0012, 16'h0abc, 16'h0007};
  isr_step_current_type i_step_current = '0;
  logic [15:0] i_servo_current = 16'hfea2;
  logic [31:0] i_move_progress = '0, i_encoder_pos = 32'h00002710;
  logic [7:0] i_reg_code = '0;
  logic o_query_ready, o_query_reject, o_format_decimal, o_tx_valid, i_tx_ready, o_reg_hit;
  logic [7:0] o_tx_data;
  logic [31:0] o_reg_data;
  int miscompares = 0;
  int checks = 0;
  always #5 i_clock = ~i_clock;
  isr_status_readback isr_status_readback_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_query_valid(i_query_valid), .i_query(i_query),
    .o_query_ready(o_query_ready), .o_query_reject(o_query_reject),
    .i_format_valid(i_format_valid), .i_format_decimal(i_format_decimal),
    .o_format_decimal(o_format_decimal), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .i_analog(i_analog), .i_servo_current(i_servo_current),
    .i_step_current(i_step_current), .i_moving(i_moving), .i_accelerating(i_accelerating),
    .i_move_start(i_move_start), .i_move_progress(i_move_progress),
    .i_encoder_pos(i_encoder_pos), .i_reg_read(i_reg_read), .i_reg_code(i_reg_code),
    .o_reg_data(o_reg_data), .o_reg_hit(o_reg_hit));
  isr_host_model isr_host_model_inst (.i_clock(i_clock), .i_reset(i_reset),
    .i_slow(host_slow), .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data),
    .o_tx_ready(i_tx_ready));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // empty body means the query must be refused
  task automatic ask(input isr_query_kind_type k, input logic hp, input logic [3:0] p,
      input string body);
    string ex;
    int n;
    ex = {"I", body};
    n = 0;
    isr_host_model_inst.got.delete();
    @(posedge i_clock);
    i_query_valid <= 1'b1;
    i_query <= '{k, hp, p};
    @(posedge i_clock);
    i_query_valid <= 1'b0;
    @(negedge i_clock);
    if (body == "") begin
      check("reject", o_query_reject, 1'b1);
    end else begin
      while (n < 2000 && !(isr_host_model_inst.got.size() > 0 &&
          isr_host_model_inst.got[$] == ISR_CH_CR)) begin
        @(negedge i_clock);
        n++;
      end
      if (n == 2000) begin
        miscompares++;
        end_of_test();
      end
      check("reply length", isr_host_model_inst.got.size(), ex.len() + 1);
      for (int i = 0; i < ex.len() && i < isr_host_model_inst.got.size(); i++) begin
        check("reply char", isr_host_model_inst.got[i], ex[i]);
      end
    end
  endtask

  task automatic set_format(input logic dec);
    @(posedge i_clock);
    i_format_valid <= 1'b1;
    i_format_decimal <= dec;
    @(posedge i_clock);
    i_format_valid <= 1'b0;
    @(negedge i_clock);
    check("format", o_format_decimal, dec);
  endtask

  task automatic reg_read(input logic [7:0] code, input logic [31:0] exp, input logic hit);
    @(posedge i_clock);
    i_reg_read <= 1'b1;
    i_reg_code <= code;
    @(posedge i_clock);
    i_reg_read <= 1'b0;
    @(negedge i_clock);
    check("reg data", o_reg_data, exp);
    check("reg hit", o_reg_hit, hit);
  endtask

  task automatic t_analog();
    ask(ISR_Q_ANALOG, 1'b0, 4'h0, "A=1FEE");
    host_slow <= 1'b1;
    ask(ISR_Q_ANALOG, 1'b1, ISR_AQ_CMD, "A=1FEE");
    ask(ISR_Q_ANALOG, 1'b1, ISR_AQ_IN1, "A=0012");
    host_slow <= 1'b0;
    ask(ISR_Q_ANALOG, 1'b1, ISR_AQ_IN2, "A=0ABC");
    ask(ISR_Q_ANALOG, 1'b1, ISR_AQ_EXP, "A=0007");
    ask(ISR_Q_ANALOG, 1'b1, 4'h4, "");
    ask(ISR_Q_CURRENT, 1'b0, 4'h0, "C=FEA2");
  endtask

  task automatic t_distance();
    @(posedge i_clock);
    i_move_start <= 1'b1;
    i_moving <= 1'b1;
    @(posedge i_clock);
    i_move_start <= 1'b0;
    i_move_progress <= 32'hffffd8f0;
    repeat (3) @(posedge i_clock);
    i_moving <= 1'b0;
    @(posedge i_clock);
    i_move_progress <= 32'h00000005;
    ask(ISR_Q_DIST, 1'b0, 4'h0, "D=FFFFD8F0");
    @(posedge i_clock);
    i_move_start <= 1'b1;
    @(posedge i_clock);
    i_move_start <= 1'b0;
    ask(ISR_Q_DIST, 1'b0, 4'h0, "D=00000000");
  endtask

  task automatic t_decimal();
    set_format(1'b1);
    host_slow <= 1'b1;
    ask(ISR_Q_ANALOG, 1'b0, 4'h0, "A=8174");
    ask(ISR_Q_ANALOG, 1'b1, ISR_AQ_IN1, "A=18");
    host_slow <= 1'b0;
    ask(ISR_Q_CURRENT, 1'b0, 4'h0, "C=-350");
    ask(ISR_Q_ENC, 1'b0, 4'h0, "E=10000");
    ask(ISR_Q_DIST, 1'b0, 4'h0, "D=0");
    // a second reset must bring back hex replies
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    i_encoder_pos <= 32'hffffd8f0;
    @(negedge i_clock);
    check("format", o_format_decimal, 1'b0);
    ask(ISR_Q_ENC, 1'b0, 4'h0, "E=FFFFD8F0");
  endtask

  task automatic t_regs();
    reg_read(ISR_RC_ANALOG_CMD, 32'h00001fee, 1'b1);
    reg_read(ISR_RC_ANALOG_IN1, 32'h00000012, 1'b1);
    reg_read(ISR_RC_ANALOG_IN2, 32'h00000abc, 1'b1);
    reg_read(ISR_RC_CURRENT, 32'hfffffea2, 1'b1);
    reg_read(ISR_RC_DIST, 32'h00000000, 1'b1);
    reg_read(ISR_RC_ENC, 32'hffffd8f0, 1'b1);
    reg_read(8'h32, 32'h00000000, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    check("format", o_format_decimal, 1'b0);
    check("ready", o_query_ready, 1'b1);
    t_analog();
    t_distance();
    t_decimal();
    t_regs();
    end_of_test();
  end
endmodule
`default_nettype wire
